// ==== inc/sstat_pkg.sv ====
package sstat_pkg;
    // form factor encodings (slot sizes)
    localparam logic [1:0] SSTAT_FF_DB32      = 2'h0;
    localparam logic [1:0] SSTAT_FF_DB20      = 2'h1;
    localparam logic [1:0] SSTAT_FF_DB13      = 2'h2;
    localparam int         SSTAT_FF_W         = 2;
    localparam int         SSTAT_IND_W        = 3;
    // reset values
    localparam logic       SSTAT_FLAG_RST     = 1'b0;
    localparam logic       SSTAT_SYNC_RST     = 1'b0;
    localparam logic [1:0] SSTAT_FF_RST       = 2'h0;
    localparam logic [2:0] SSTAT_IND_RST      = 3'h0;
endpackage

// ==== hdl/sstat_slot_status.sv ====
`timescale 1ns/1ns
// Overview of operation
// - each slot reports, read only, which of the three slot sizes it is built as.
// - when the lock is fitted, each slot shows whether its security lock is engaged or released.
// - the lock state bit is status only and no write changes the bit or the lock.
// - read-only slot state bits always follow the slot state machine that drives the indicator.
// - a removal button press sets the slot's removal request flag and raises its interrupt until cleared.
// - writing one to the removal request flag clears it.
// - inserting the first device or removing the last one sets the slot's change flag and raises its interrupt; write one clears it.
// - per-slot presence bits for serial-bus and usb devices tell insertion from removal.
module sstat_slot_status
    import sstat_pkg::*;
#(
    parameter int N_SLOTS = 2
) (
    input  wire logic                           i_mclk,
    input  wire logic                           i_rst,
    input  wire logic [N_SLOTS*SSTAT_FF_W-1:0]  i_slot_form_factor,
    input  wire logic                           i_lock_fitted_flag,
    input  wire logic [N_SLOTS-1:0]             i_lock_engaged,
    input  wire logic [N_SLOTS*SSTAT_IND_W-1:0] i_slot_indicator_state,
    input  wire logic [N_SLOTS-1:0]             i_removal_button,
    input  wire logic [N_SLOTS-1:0]             i_ieee1394_present,
    input  wire logic [N_SLOTS-1:0]             i_usb_present,
    input  wire logic [N_SLOTS-1:0]             i_clr_removal_request,
    input  wire logic [N_SLOTS-1:0]             i_clr_device_change,
    output logic      [N_SLOTS*SSTAT_FF_W-1:0]  o_slot_form_factor,
    output logic      [N_SLOTS-1:0]             o_security_lock_state,
    output logic      [N_SLOTS*SSTAT_IND_W-1:0] o_slot_indicator_state,
    output logic      [N_SLOTS-1:0]             o_removal_request_flag,
    output logic      [N_SLOTS-1:0]             o_device_change_flag,
    output logic      [N_SLOTS-1:0]             o_ieee1394_present_flag,
    output logic      [N_SLOTS-1:0]             o_usb_present_flag,
    output logic      [N_SLOTS-1:0]             o_slot_irq
);
    genvar g;
    generate
        for (g = 0; g < N_SLOTS; g++) begin : g_slot
            // lowest bit of this slot in the packed buses
            localparam int FF_LO  = g * SSTAT_FF_W;
            localparam int IND_LO = g * SSTAT_IND_W;
            // synchroniser stages; bit 3 lock, 2 button, 1 serial bus, 0 usb
            logic [3:0]             s1_reg;
            logic [3:0]             s1_next;
            logic [3:0]             s2_reg;
            logic [3:0]             s2_next;
            // edge history, fed from stage two only
            logic                   btn_d_reg;
            logic                   btn_d_next;
            logic                   prs_d_reg;
            logic                   prs_d_next;
            // sticky event flags and the slot interrupt
            logic                   rem_reg;
            logic                   rem_next;
            logic                   chg_reg;
            logic                   chg_next;
            logic                   irq_reg;
            logic                   irq_next;
            // registered status copies
            logic                   lock_reg;
            logic                   lock_next;
            logic [SSTAT_FF_W-1:0]  ff_reg;
            logic [SSTAT_FF_W-1:0]  ff_next;
            logic [SSTAT_IND_W-1:0] ind_reg;
            logic [SSTAT_IND_W-1:0] ind_next;
            // named taps of the synchroniser
            logic                   lock_sync;
            logic                   btn_sync;
            logic                   ieee_sync;
            logic                   usb_sync;
            logic                   prs_now;
            logic                   btn_rise;
            logic                   prs_toggle;

            // pins are asynchronous; nothing but stage two reads stage one
            always_comb begin
                s1_next = {i_lock_engaged[g], i_removal_button[g], i_ieee1394_present[g], i_usb_present[g]};
                s2_next = s1_reg;
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    s1_reg <= {4{SSTAT_SYNC_RST}};
                    s2_reg <= {4{SSTAT_SYNC_RST}};
                end else begin
                    s1_reg <= s1_next;
                    s2_reg <= s2_next;
                end
            end

            assign lock_sync = s2_reg[3];
            assign btn_sync  = s2_reg[2];
            assign ieee_sync = s2_reg[1];
            assign usb_sync  = s2_reg[0];
            assign prs_now   = ieee_sync | usb_sync;

            // button history resets to the released level, so reset makes no false press
            always_comb begin
                btn_d_next = btn_sync;
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    btn_d_reg <= SSTAT_SYNC_RST;
                end else begin
                    btn_d_reg <= btn_d_next;
                end
            end

            assign btn_rise = btn_sync & ~btn_d_reg;

            // a device already seated at reset shows up as one change event
            always_comb begin
                prs_d_next = prs_now;
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    prs_d_reg <= SSTAT_SYNC_RST;
                end else begin
                    prs_d_reg <= prs_d_next;
                end
            end

            assign prs_toggle = prs_now ^ prs_d_reg;

            // removal flag: set wins over a same-cycle clear, a zero write does nothing
            always_comb begin
                rem_next = rem_reg;
                if (i_clr_removal_request[g]) begin
                    rem_next = 1'b0;
                end
                if (btn_rise) begin
                    rem_next = 1'b1;
                end
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    rem_reg <= SSTAT_FLAG_RST;
                end else begin
                    rem_reg <= rem_next;
                end
            end

            // change flag: the OR of the two presence bits toggling marks an insertion or removal
            always_comb begin
                chg_next = chg_reg;
                if (i_clr_device_change[g]) begin
                    chg_next = 1'b0;
                end
                if (prs_toggle) begin
                    chg_next = 1'b1;
                end
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    chg_reg <= SSTAT_FLAG_RST;
                end else begin
                    chg_reg <= chg_next;
                end
            end

            // irq taken from the next flag values so it lines up with the flags
            always_comb begin
                irq_next = rem_next | chg_next;
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    irq_reg <= SSTAT_FLAG_RST;
                end else begin
                    irq_reg <= irq_next;
                end
            end

            // lock bit has no write path; it only follows the sensor while fitted
            always_comb begin
                lock_next = i_lock_fitted_flag & lock_sync;
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    lock_reg <= SSTAT_FLAG_RST;
                end else begin
                    lock_reg <= lock_next;
                end
            end

            // form factor is strapped per slot, copied through one flop
            always_comb begin
                ff_next = i_slot_form_factor[FF_LO +: SSTAT_FF_W];
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    ff_reg <= SSTAT_FF_RST;
                end else begin
                    ff_reg <= ff_next;
                end
            end

            // indicator follows the slot state machine one cycle late
            always_comb begin
                ind_next = i_slot_indicator_state[IND_LO +: SSTAT_IND_W];
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    ind_reg <= SSTAT_IND_RST;
                end else begin
                    ind_reg <= ind_next;
                end
            end

            assign o_slot_form_factor[FF_LO +: SSTAT_FF_W]       = ff_reg;
            assign o_slot_indicator_state[IND_LO +: SSTAT_IND_W] = ind_reg;
            assign o_security_lock_state[g]   = lock_reg;
            assign o_removal_request_flag[g]  = rem_reg;
            assign o_device_change_flag[g]    = chg_reg;
            assign o_ieee1394_present_flag[g] = ieee_sync;
            assign o_usb_present_flag[g]      = usb_sync;
            assign o_slot_irq[g]              = irq_reg;
        end
    endgenerate
endmodule

// ==== verification/sstat_slot_status_checker.sv ====
`timescale 1ns/1ns
module sstat_slot_status_checker #(parameter int N_SLOTS = 2) (input wire logic i_mclk, i_rst, i_lock_fitted_flag,
    input wire logic [N_SLOTS-1:0] i_removal_button, i_clr_removal_request, i_clr_device_change, i_usb_present,
    input wire logic [N_SLOTS-1:0] o_removal_request_flag, o_device_change_flag, o_slot_irq, o_security_lock_state,
    input wire logic [N_SLOTS-1:0] o_usb_present_flag);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    AST_LK: assert property (!$past(i_lock_fitted_flag) |-> !o_security_lock_state) else $error("lk");
    AST_RS: assert property ($rose(i_removal_button[0]) |-> ##3 o_removal_request_flag[0]) else $error("rs");
    AST_RR: assert property ($rose(o_removal_request_flag[0]) |-> $past(i_removal_button[0], 3)) else $error("rr");
    AST_RC: assert property (i_clr_removal_request[0] && !$past(i_removal_button[0], 2)
        |=> !o_removal_request_flag[0]) else $error("rc");
    AST_RF: assert property ($fell(o_removal_request_flag[0]) |-> $past(i_clr_removal_request[0]))
        else $error("rf");
    AST_DF: assert property ($fell(o_device_change_flag[0]) |-> $past(i_clr_device_change[0]))
        else $error("df");
    AST_IQ: assert property (o_slot_irq == (o_removal_request_flag | o_device_change_flag)) else $error("iq");
    AST_PR: assert property (!$past(i_rst) |-> o_usb_present_flag == $past(i_usb_present, 2)) else $error("pr");
    cover property ($fell(o_removal_request_flag[0]));
    cover property ($rose(o_device_change_flag[0]));
    cover property ($rose(o_security_lock_state[0]));
endmodule
bind sstat_slot_status sstat_slot_status_checker #(.N_SLOTS(N_SLOTS)) chk (.*);

// ==== verification/test_sstat_slot_status.sv ====
`timescale 1ns/1ns
module test_sstat_slot_status;
    logic        i_mclk = 0, i_rst = 1, i_lock_fitted_flag;
    logic [20:0] r = 0;
    logic [9:0]  x;
    logic [5:0]  h1, h2, h3, i_slot_indicator_state, o_slot_indicator_state;
    logic [3:0]  i_slot_form_factor, o_slot_form_factor;
    logic [1:0]  rr, dc, i_lock_engaged, i_removal_button, i_ieee1394_present, i_usb_present, i_clr_device_change;
    logic [1:0]  i_clr_removal_request, o_security_lock_state, o_removal_request_flag, o_device_change_flag, o_slot_irq;
    logic [1:0]  o_ieee1394_present_flag, o_usb_present_flag, l1, l2, lk;
    int          seed = 32'h9923, t, miscompares = 0, samples_checked = 0;
    sstat_slot_status uut (.*);
    assign {i_removal_button, i_usb_present, i_ieee1394_present, i_clr_removal_request, i_clr_device_change,
        i_lock_engaged, i_lock_fitted_flag, i_slot_indicator_state} = r[18:0];
    assign i_slot_form_factor = {1'b0, r[20:19], 1'b0};
    initial forever #2 i_mclk = ~i_mclk;
    task automatic check(input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %0t %h %h", $time, s, e);
        end
    endtask
    task automatic complete_run;
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        if (i_rst) {h1, h2, h3, rr, dc, x, l1, l2, lk} = 0;
        else begin
            lk = {2{i_lock_fitted_flag}} & l2;
            {l2, l1} = {l1, i_lock_engaged};
            rr = rr & ~i_clr_removal_request | h2[5:4] & ~h3[5:4];
            dc = dc & ~i_clr_device_change | (h2[3:2] | h2[1:0]) ^ (h3[3:2] | h3[1:0]);
            {h3, h2, h1} = {h2, h1, r[18:13]};
            x = {i_slot_form_factor, i_slot_indicator_state};
        end
    end
    initial begin
        repeat (5) @(posedge i_mclk);
        #1 i_rst = 0;
        for (int i = 0; i < 800; i++) begin
            @(posedge i_mclk);
            #1 check({o_removal_request_flag, o_device_change_flag, o_slot_irq, o_usb_present_flag, o_ieee1394_present_flag,
                o_slot_form_factor, o_slot_indicator_state}, {rr, dc, rr | dc, h2[3:0], x});
            check(o_security_lock_state, lk);
            t = $random(seed);
            r = i[2] ? t[20:0] : {t[20:19], r[18:13], t[12:0]}; // pins held half the time so clears can win
        end
        r = 21'h1f40;
        repeat (6) @(posedge i_mclk);
        #1 check(o_security_lock_state, 2'h2);
        complete_run();
    end
endmodule
